// file: bsc_top.sv
// bsc_top: later burner sequence (ignition trials, run, postpurge)
// assumes field inputs are asynchronous and synchronised here
`timescale 1ns/100ps
// Function
// - direct spark: ignition and both valves together
// - direct spark: flame proven at 4 s
// - proven flame: ignition off, enter run
// - run starts with ten second stabilization
// - then release firing motor to modulation
// - stay in run until demand opens
// - postpurge programmable, default 15 s, blower on
// - postpurge start: valves off, low fire
// - valve check runs during postpurge, then finish
// - valve check without spark: 10 s main period
// - test holds drive to high fire
// - test freezes purge timer unless valve checking
// - test holds drive to low fire
// - test stops pilot timer early, flameout timer
// - test ignored in pilot period when valve outputs strapped
// - test in run commands low fire
// - test mode stops at next hold point
// - pilot link: intact 10 s, clipped 4 s
// - spark link skips pilot on valve-check demand, main 4 s
// - strap extends main period unless valve checking
// - postpurge interlock fault shuts down
module bsc_top
  import bsc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // field inputs
  input wire logic DEMAND,
  input wire logic VP_DEMAND,
  input wire logic PRE_IGN_ILK,
  input wire logic LOCKOUT_ILK,
  input wire logic HIGH_FIRE_SW,
  input wire logic LOW_FIRE_SW,
  input wire logic FLAME,
  input wire logic TEST_SW,
  input wire logic VALVE_STRAP,
  input wire logic MAIN_FLAME_PERIOD_STRAP,
  input wire logic VP_SW,
  // option links, high when intact
  input wire logic PILOT_PERIOD_LINK,
  input wire logic SPARK_OPTION_LINK_A,
  // outputs to the field
  output logic IGNITION,
  output logic PILOT_VALVE,
  output logic UPSTREAM_FUEL_VALVE,
  output logic DOWNSTREAM_FUEL_VALVE,
  output logic BLOWER,
  output logic FIRE_HIGH,
  output logic FIRE_LOW,
  output logic MODULATE,
  output logic LOCKOUT,
  // axi4-lite slave
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY
);
  localparam int NSYNC = 13;

  typedef struct packed {
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [23:0] div;
    logic tick;
    bsc_state_e st;
    logic [15:0] tmr;
    logic [15:0] aux;
    logic [15:0] vpt;
    logic vp_busy;
    logic test_hold;
    logic vp_demand_used;
    logic [15:0] post_set;
    logic [15:0] vp_set;
    logic vp_after;
    logic restart;
    logic ign;
    logic pv;
    logic uv;
    logic dv;
    logic blow;
    logic fhi;
    logic flo;
    logic mod;
    logic lock;
    logic aw_got;
    logic w_got;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bv;
    logic [1:0] br;
    logic rv;
    logic [31:0] rd;
    logic [1:0] rr;
  } bsc_regs_s;

  bsc_regs_s r;
  bsc_regs_s n;

  // synchronised input names
  logic demand_s, vpdem_s, pii_s, lilk_s, hfs_s, lfs_s, flame_s;
  logic test_s, strap_s, mstrap_s, vpsw_s, plink_s, slink_s;
  logic active_demand, dsi;
  logic [15:0] main_flame_period_len, pilot_flame_period_len, pilot_flame_period_test_len;

  // bit order of the synchroniser vector
  assign {demand_s, vpdem_s, pii_s, lilk_s, hfs_s, lfs_s, flame_s,
          test_s, strap_s, mstrap_s, vpsw_s, plink_s, slink_s} = r.s2;

  // clamp postpurge setting to its allowed range
  function automatic logic [15:0] clamp_post(input logic [15:0] v);
    clamp_post = (v > POST_MAX_S) ? POST_MAX_S : v;
  endfunction

  // =====================================================================
  // sequencer and register bus
  // =====================================================================
  always_comb
  begin
    n = r;
    n.s1 = {DEMAND, VP_DEMAND, PRE_IGN_ILK, LOCKOUT_ILK, HIGH_FIRE_SW,
            LOW_FIRE_SW, FLAME, TEST_SW, VALVE_STRAP, MAIN_FLAME_PERIOD_STRAP, VP_SW,
            PILOT_PERIOD_LINK, SPARK_OPTION_LINK_A};
    n.s2 = r.s1;
    // one second tick from the system clock
    n.tick = 1'b0;
    if (r.div == 24'(TICK_CYCLES - 1))
    begin
      n.div = 24'h000000;
      n.tick = 1'b1;
    end
    else
      n.div = r.div + 24'h000001;
    // demand input in use: valve-check demand when wired
    active_demand = r.vp_demand_used ? vpdem_s : demand_s;
    dsi = slink_s && r.vp_demand_used;
    // main flame period selection
    if (dsi)
      main_flame_period_len = DSI_MAIN_FLAME_PERIOD_S;
    else if (r.vp_demand_used)
      main_flame_period_len = VP_MAIN_FLAME_PERIOD_S;
    else if (mstrap_s)
      main_flame_period_len = LONG_MAIN_FLAME_PERIOD_S;
    else
      main_flame_period_len = VP_MAIN_FLAME_PERIOD_S;
    // pilot period from the link
    pilot_flame_period_len = plink_s ? PILOT_FLAME_PERIOD_LONG_S : PILOT_FLAME_PERIOD_SHORT_S;
    pilot_flame_period_test_len = plink_s ? PILOT_FLAME_PERIOD_TEST_LONG_S : PILOT_FLAME_PERIOD_TEST_SHORT_S;
    n.test_hold = 1'b0;
    case (r.st)
      ST_STANDBY:
      begin
        n.ign = 1'b0; n.pv = 1'b0; n.uv = 1'b0; n.dv = 1'b0;
        n.blow = 1'b0; n.mod = 1'b0; n.fhi = 1'b0; n.flo = 1'b0;
        n.tmr = 16'h0000;
        n.aux = 16'h0000;
        if (vpdem_s || demand_s)
        begin
          n.vp_demand_used = vpdem_s;
          n.st = ST_PRE_HIGH;
        end
      end
      ST_PRE_HIGH:
      begin
        n.blow = 1'b1; n.fhi = 1'b1; n.flo = 1'b0;
        // test holds the drive to high fire
        n.test_hold = test_s;
        if (hfs_s && lilk_s && !test_s)
          n.st = ST_PRE_TIMED;
      end
      ST_PRE_TIMED:
      begin
        // test freezes timing, not while valve checking
        n.test_hold = test_s && !r.vp_busy;
        if (r.tick && !n.test_hold)
          n.tmr = r.tmr + 16'h0001;
        if (r.tmr >= STAB_S)
        begin
          n.tmr = 16'h0000;
          n.st = ST_PRE_LOW;
        end
      end
      ST_PRE_LOW:
      begin
        n.fhi = 1'b0; n.flo = 1'b1;
        // test holds the drive to low fire
        n.test_hold = test_s;
        if (lfs_s && !test_s)
        begin
          n.tmr = 16'h0000;
          if (dsi)
          begin
            // spark and both valves in one cycle
            n.ign = 1'b1; n.uv = 1'b1; n.dv = 1'b1;
            n.st = ST_MAIN_FLAME_PERIOD;
          end
          else
          begin
            n.ign = 1'b1; n.pv = 1'b1;
            n.st = ST_PILOT_FLAME_PERIOD;
          end
        end
      end
      ST_PILOT_FLAME_PERIOD:
      begin
        // test stops the early timer unless valves strapped
        n.test_hold = test_s && !strap_s && r.tmr < pilot_flame_period_test_len;
        if (r.tick && !n.test_hold)
          n.tmr = r.tmr + 16'h0001;
        // fifteen second flameout timer while held
        if (!n.test_hold || flame_s)
          n.aux = 16'h0000;
        else if (r.tick)
          n.aux = r.aux + 16'h0001;
        if (r.aux >= FLAMEOUT_S)
          n.st = ST_LOCKOUT;
        else if (r.tmr >= pilot_flame_period_len)
        begin
          n.tmr = 16'h0000;
          if (flame_s)
          begin
            n.ign = 1'b0; n.uv = 1'b1;
            n.dv = r.vp_demand_used;
            n.st = ST_MAIN_FLAME_PERIOD;
          end
          else
            n.st = ST_LOCKOUT;
        end
      end
      ST_MAIN_FLAME_PERIOD:
      begin
        if (r.tick)
          n.tmr = r.tmr + 16'h0001;
        // flame proven at end of main period
        if (r.tmr >= main_flame_period_len)
        begin
          if (flame_s)
          begin
            // ignition off, into run
            n.ign = 1'b0; n.pv = 1'b0;
            n.tmr = 16'h0000;
            n.st = ST_RUN;
          end
          else
            n.st = ST_LOCKOUT;
        end
      end
      ST_RUN:
      begin
        // stabilization before release
        if (r.tick && r.tmr < STAB_S)
          n.tmr = r.tmr + 16'h0001;
        // release to modulation, test forces low fire
        n.mod = (r.tmr >= STAB_S) && !test_s;
        n.flo = !n.mod;
        n.test_hold = test_s;
        if (!flame_s || !lilk_s)
          n.st = ST_LOCKOUT;
        else if (!active_demand)
        begin
          // postpurge entry: valves off, low fire
          n.uv = 1'b0; n.dv = 1'b0; n.pv = 1'b0; n.ign = 1'b0;
          n.mod = 1'b0; n.flo = 1'b1;
          n.tmr = 16'h0000;
          n.aux = 16'h0000;
          n.vp_busy = r.vp_after && r.vp_demand_used;
          n.vpt = 16'h0000;
          n.st = ST_POST;
        end
      end
      ST_POST:
      begin
        n.blow = 1'b1;
        if (r.tick && r.tmr < r.post_set)
          n.tmr = r.tmr + 16'h0001;
        // valve check runs alongside postpurge
        if (r.vp_busy)
        begin
          n.uv = r.vpt < (r.vp_set >> 1);
          if (r.tick)
            n.vpt = r.vpt + 16'h0001;
          if (r.vpt >= r.vp_set)
          begin
            n.vp_busy = 1'b0;
            n.uv = 1'b0;
          end
        end
        // interlock must close in 5 s and stay closed
        if (r.tick && r.aux < PII_S)
          n.aux = r.aux + 16'h0001;
        if (!r.vp_busy && !pii_s && r.aux >= PII_S)
          n.st = ST_LOCKOUT;
        else if (!r.vp_busy && r.tmr >= r.post_set)
        begin
          n.blow = 1'b0; n.flo = 1'b0;
          n.st = ST_STANDBY;
        end
      end
      ST_LOCKOUT:
      begin
        n.ign = 1'b0; n.pv = 1'b0; n.uv = 1'b0; n.dv = 1'b0;
        n.mod = 1'b0; n.fhi = 1'b0; n.flo = 1'b0; n.blow = 1'b0;
        n.vp_busy = 1'b0;
        if (r.restart)
          n.st = ST_STANDBY;
      end
      default:
        n.st = ST_LOCKOUT;
    endcase
    n.lock = (n.st == ST_LOCKOUT);
    n.restart = 1'b0;
    // axi write: take address and data in either order
    if (AWVALID && AWREADY)
    begin
      n.aw_got = 1'b1;
      n.awa = AWADDR;
    end
    if (WVALID && WREADY)
    begin
      n.w_got = 1'b1;
      n.wd = WDATA;
      n.ws = WSTRB;
    end
    if (r.aw_got && r.w_got && !r.bv)
    begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bv = 1'b1;
      n.br = RESP_OKAY;
      case (r.awa)
        CTRL_OFS:
        begin
          if (r.ws[0])
          begin
            n.vp_after = r.wd[CTRL_VP_AFTER];
            n.restart = r.wd[CTRL_RESTART];
          end
        end
        POST_OFS:
          if (r.ws[0] && r.ws[1])
            n.post_set = clamp_post(r.wd[15:0]);
        VPT_OFS:
          if (r.ws[0] && r.ws[1])
            n.vp_set = r.wd[15:0];
        STAT_OFS, TIMER_OFS:
          n.br = RESP_OKAY;
        default:
          n.br = RESP_SLVERR;
      endcase
    end
    if (r.bv && BREADY)
      n.bv = 1'b0;
    // axi read: answer one cycle after the address is taken
    if (ARVALID && ARREADY)
    begin
      n.rv = 1'b1;
      n.rr = RESP_OKAY;
      case (ARADDR)
        CTRL_OFS: n.rd = {30'h00000000, 1'b0, r.vp_after};
        POST_OFS: n.rd = {16'h0000, r.post_set};
        VPT_OFS: n.rd = {16'h0000, r.vp_set};
        STAT_OFS: n.rd = {22'h000000, r.vp_busy, r.test_hold,
                          r.vp_demand_used, r.lock, 2'h0,
                          4'(r.st)};
        TIMER_OFS: n.rd = {r.aux, r.tmr};
        default:
        begin
          n.rd = 32'h00000000;
          n.rr = RESP_SLVERR;
        end
      endcase
    end
    else if (r.rv && RREADY)
      n.rv = 1'b0;
  end

  // =====================================================================
  // state register
  // =====================================================================
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      r <= '0;
      r.st <= ST_STANDBY;
      r.post_set <= POST_DEF_S;
      r.vp_set <= VP_DEF_S;
    end
    else
      r <= n;
  end

  // output drive, all from flip-flops
  assign IGNITION = r.ign;
  assign PILOT_VALVE = r.pv;
  assign UPSTREAM_FUEL_VALVE = r.uv;
  assign DOWNSTREAM_FUEL_VALVE = r.dv;
  assign BLOWER = r.blow;
  assign FIRE_HIGH = r.fhi;
  assign FIRE_LOW = r.flo;
  assign MODULATE = r.mod;
  assign LOCKOUT = r.lock;
  assign AWREADY = !r.aw_got;
  assign WREADY = !r.w_got;
  assign BVALID = r.bv;
  assign BRESP = r.br;
  assign ARREADY = !r.rv;
  assign RVALID = r.rv;
  assign RDATA = r.rd;
  assign RRESP = r.rr;
endmodule

// file: bsc_pkg.sv
// bsc_pkg: constants, register map and state type for the burner sequencer
// assumes a 10 MHz system clock and a 32-bit axi4-lite register bus
package bsc_pkg;
  // =====================================================================
  // timing
  // =====================================================================
  localparam int CLK_HZ = 10000000;
  localparam int TICK_S = 1;
  localparam int TICK_CYC = CLK_HZ * TICK_S;
  localparam logic [15:0] DSI_MAIN_FLAME_PERIOD_S = 16'h0004;
  localparam logic [15:0] VP_MAIN_FLAME_PERIOD_S = 16'h000a;
  localparam logic [15:0] LONG_MAIN_FLAME_PERIOD_S = 16'h001e;
  localparam logic [15:0] STAB_S = 16'h000a;
  localparam logic [15:0] PILOT_FLAME_PERIOD_LONG_S = 16'h000a;
  localparam logic [15:0] PILOT_FLAME_PERIOD_SHORT_S = 16'h0004;
  localparam logic [15:0] PILOT_FLAME_PERIOD_TEST_LONG_S = 16'h0008;
  localparam logic [15:0] PILOT_FLAME_PERIOD_TEST_SHORT_S = 16'h0003;
  localparam logic [15:0] FLAMEOUT_S = 16'h000f;
  localparam logic [15:0] PII_S = 16'h0005;
  localparam logic [15:0] POST_DEF_S = 16'h000f;
  localparam logic [15:0] POST_MAX_S = 16'h0f78;
  localparam logic [15:0] VP_DEF_S = 16'h000a;
  // =====================================================================
  // registers
  // =====================================================================
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] POST_OFS = 8'h04;
  localparam logic [7:0] VPT_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0c;
  localparam logic [7:0] TIMER_OFS = 8'h10;
  // ctrl fields: bit0 vp_after, bit1 restart request
  localparam int CTRL_VP_AFTER = 0;
  localparam int CTRL_RESTART = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    ST_STANDBY, ST_PRE_HIGH, ST_PRE_TIMED, ST_PRE_LOW, ST_PILOT_FLAME_PERIOD,
    ST_MAIN_FLAME_PERIOD, ST_RUN, ST_POST, ST_LOCKOUT
  } bsc_state_e;
endpackage

// file: bsc_properties.sv
// bsc_properties: concurrent checks on the sequencer's field pins
// assumes binding into bsc_top, one clock, synchronous reset
`timescale 1ns/100ps
module bsc_chk
  import bsc_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // field inputs
  input wire logic DEMAND,
  input wire logic VP_DEMAND,
  input wire logic LOCKOUT_ILK,
  input wire logic FLAME,
  input wire logic TEST_SW,
  input wire logic SPARK_OPTION_LINK_A,
  // field outputs
  input wire logic IGNITION,
  input wire logic PILOT_VALVE,
  input wire logic UPSTREAM_FUEL_VALVE,
  input wire logic DOWNSTREAM_FUEL_VALVE,
  input wire logic BLOWER,
  input wire logic FIRE_HIGH,
  input wire logic FIRE_LOW,
  input wire logic MODULATE,
  input wire logic LOCKOUT
);
  // =====================================================================
  // helper history and counters
  // =====================================================================
  localparam int T = TICK_CYCLES;
  int ign_cnt;
  int run_cnt;
  int post_cnt;
  logic [3:0] ok_sr;
  logic [3:0] tst_sr;
  logic ok_now;
  logic tst_now;
  // steady demand and interlock, run or test position
  assign ok_now = DEMAND && VP_DEMAND && FLAME && LOCKOUT_ILK && !TEST_SW;
  assign tst_now = DEMAND && VP_DEMAND && LOCKOUT_ILK && TEST_SW;
  // spark time, run-like valve time, blower time after demand drops
  always_ff @(posedge CLK)
  begin
    if (RST)
    begin
      ign_cnt <= 0;
      run_cnt <= 0;
      post_cnt <= 0;
      ok_sr <= 4'h0;
      tst_sr <= 4'h0;
    end
    else
    begin
      ign_cnt <= IGNITION ? ign_cnt + 1 : 0;
      run_cnt <= (UPSTREAM_FUEL_VALVE && !IGNITION && !PILOT_VALVE) ?
                 run_cnt + 1 : 0;
      post_cnt <= (BLOWER && !DEMAND && !VP_DEMAND) ? post_cnt + 1 : 0;
      ok_sr <= {ok_sr[2:0], ok_now};
      tst_sr <= {tst_sr[2:0], tst_now};
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  // =====================================================================
  // assertions
  // =====================================================================
  a_dsi_together: assert property (($rose(IGNITION) && VP_DEMAND &&
    SPARK_OPTION_LINK_A) |-> UPSTREAM_FUEL_VALVE && DOWNSTREAM_FUEL_VALVE)
    else $error("direct spark valves not opened with ignition");
  a_spark_bound: assert property ($fell(IGNITION) &&
    $past(DOWNSTREAM_FUEL_VALVE) |-> ign_cnt <= 4 * T + 2)
    else $error("direct spark period too long");
  a_no_flame_lock: assert property ((ign_cnt >= 3 * T &&
    $fell(IGNITION) && $past(DOWNSTREAM_FUEL_VALVE) && !FLAME &&
    !$past(FLAME, 2) && VP_DEMAND) |-> ##[0:2] LOCKOUT)
    else $error("missing lockout without flame");
  a_spark_to_run: assert property ((ign_cnt >= 3 * T &&
    $fell(IGNITION) && $past(DOWNSTREAM_FUEL_VALVE) && (&ok_sr))
    |-> UPSTREAM_FUEL_VALVE && !LOCKOUT)
    else $error("proven flame did not enter run");
  a_stab_first: assert property ($rose(MODULATE)
    |-> run_cnt >= 9 * T)
    else $error("modulation released before stabilization");
  a_mod_release: assert property ((run_cnt == 11 * T + 4 &&
    SPARK_OPTION_LINK_A && (&ok_sr) && ok_now) |-> MODULATE)
    else $error("modulation not released after stabilization");
  a_run_holds: assert property ((MODULATE && (&ok_sr) && ok_now)
    |=> UPSTREAM_FUEL_VALVE && MODULATE)
    else $error("run left while demand held");
  a_post_start: assert property (($fell(UPSTREAM_FUEL_VALVE) &&
    BLOWER && !LOCKOUT) |-> !DOWNSTREAM_FUEL_VALVE && !PILOT_VALVE &&
    FIRE_LOW && !MODULATE)
    else $error("postpurge start outputs wrong");
  a_post_length: assert property (($fell(BLOWER) && !LOCKOUT)
    |-> post_cnt >= 14 * T)
    else $error("postpurge too short");
  a_hold_high: assert property (((&tst_sr) && tst_now && FIRE_HIGH &&
    !LOCKOUT) |=> FIRE_HIGH && !IGNITION)
    else $error("test position did not hold high fire");
  a_test_low: assert property ((run_cnt > 11 * T + 4 && (&tst_sr) &&
    tst_now && FLAME && $past(FLAME, 3)) |-> !MODULATE && FIRE_LOW)
    else $error("test in run did not command low fire");
endmodule
bind bsc_top bsc_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.CLK(CLK),
  .RST(RST), .DEMAND(DEMAND), .VP_DEMAND(VP_DEMAND), .FLAME(FLAME),
  .LOCKOUT_ILK(LOCKOUT_ILK), .TEST_SW(TEST_SW), .IGNITION(IGNITION),
  .SPARK_OPTION_LINK_A(SPARK_OPTION_LINK_A), .PILOT_VALVE(PILOT_VALVE),
  .UPSTREAM_FUEL_VALVE(UPSTREAM_FUEL_VALVE), .BLOWER(BLOWER),
  .DOWNSTREAM_FUEL_VALVE(DOWNSTREAM_FUEL_VALVE), .FIRE_HIGH(FIRE_HIGH),
  .FIRE_LOW(FIRE_LOW), .MODULATE(MODULATE), .LOCKOUT(LOCKOUT));

// file: bsc_field.sv
// bsc_field: burner, flame sensor, switches and valve closure proof
// assumes the sequencer outputs as inputs; flame_en lets a test fail
`timescale 1ns/100ps
module bsc_field (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // test control
  input wire logic flame_en,
  // sequencer outputs
  input wire logic ign,
  input wire logic pilot,
  input wire logic up,
  input wire logic down,
  input wire logic fire_high,
  input wire logic fire_low,
  // field answers
  output logic flame,
  output logic high_sw,
  output logic low_sw,
  output logic lock_ilk,
  output logic pre_ilk
);
  int shut_cnt;
  // lockout interlock string stays made
  assign lock_ilk = 1'b1;
  // flame lights under spark and lives while fuel flows; motor follows
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      flame <= 1'b0;
      high_sw <= 1'b0;
      low_sw <= 1'b0;
      shut_cnt <= 20;
    end
    else
    begin
      flame <= flame_en && (pilot || up) && (ign || flame);
      high_sw <= fire_high;
      low_sw <= fire_low;
      shut_cnt <= (up || down) ? 0 : shut_cnt + (shut_cnt < 20 ? 1 : 0);
    end
  end
  // closure proof makes 20 cycles after the valves shut
  assign pre_ilk = shut_cnt >= 20;
endmodule

// file: burner_sequence_controller_tb.sv
// burner_sequence_controller_tb: register and sequence checks
// assumes bsc_top with a 10-cycle second and the bsc_field model
`timescale 1ns/100ps
module burner_sequence_controller_tb;
  import bsc_pkg::*;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [1:0] r;} bsc_row_s;
  localparam int IG = 0;
  localparam int UP = 2;
  localparam int BW = 4;
  localparam int MD = 7;
  localparam int LK = 8;
  logic CLK = 0, RST = 1, DEMAND = 0, VP_DEMAND = 0, TEST_SW = 0;
  logic PILOT_PERIOD_LINK = 0, SPARK_OPTION_LINK_A = 1, flame_en = 1;
  logic PRE_IGN_ILK, LOCKOUT_ILK, HIGH_FIRE_SW, LOW_FIRE_SW, FLAME;
  logic IGNITION, PILOT_VALVE, UPSTREAM_FUEL_VALVE, DOWNSTREAM_FUEL_VALVE;
  logic BLOWER, FIRE_HIGH, FIRE_LOW, MODULATE, LOCKOUT, AWREADY, WREADY;
  logic BVALID, ARREADY, RVALID, AWVALID = 0, WVALID = 0, BREADY = 0;
  logic ARVALID = 0, RREADY = 0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0, RDATA, rd;
  logic [3:0] WSTRB = 4'hf;
  logic [1:0] BRESP, RRESP, rs;
  logic [8:0] outs;
  int err_count = 0, checks = 0, cyc = 0, n;
  bsc_row_s rows [6] = '{'{8'h00, 0, RESP_OKAY}, '{8'h04, 15, RESP_OKAY},
    '{8'h08, 10, RESP_OKAY}, '{8'h0c, 0, RESP_OKAY},
    '{8'h10, 0, RESP_OKAY}, '{8'h20, 0, RESP_SLVERR}};
  assign outs = {LOCKOUT, MODULATE, FIRE_LOW, FIRE_HIGH, BLOWER,
    DOWNSTREAM_FUEL_VALVE, UPSTREAM_FUEL_VALVE, PILOT_VALVE, IGNITION};
  bsc_top #(.TICK_CYCLES(10)) dut (.CLK(CLK), .RST(RST), .DEMAND(DEMAND),
    .VP_DEMAND(VP_DEMAND), .PRE_IGN_ILK(PRE_IGN_ILK), .FLAME(FLAME),
    .LOCKOUT_ILK(LOCKOUT_ILK), .HIGH_FIRE_SW(HIGH_FIRE_SW),
    .LOW_FIRE_SW(LOW_FIRE_SW), .TEST_SW(TEST_SW), .VALVE_STRAP(1'b0),
    .MAIN_FLAME_PERIOD_STRAP(1'b0), .VP_SW(1'b0), .PILOT_PERIOD_LINK(PILOT_PERIOD_LINK),
    .SPARK_OPTION_LINK_A(SPARK_OPTION_LINK_A), .IGNITION(IGNITION),
    .PILOT_VALVE(PILOT_VALVE), .UPSTREAM_FUEL_VALVE(UPSTREAM_FUEL_VALVE),
    .DOWNSTREAM_FUEL_VALVE(DOWNSTREAM_FUEL_VALVE), .BLOWER(BLOWER),
    .FIRE_HIGH(FIRE_HIGH), .FIRE_LOW(FIRE_LOW), .MODULATE(MODULATE),
    .LOCKOUT(LOCKOUT), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
  bsc_field field (.clk(CLK), .rst(RST), .flame_en(flame_en),
    .ign(IGNITION), .pilot(PILOT_VALVE), .up(UPSTREAM_FUEL_VALVE),
    .down(DOWNSTREAM_FUEL_VALVE), .fire_high(FIRE_HIGH),
    .fire_low(FIRE_LOW), .flame(FLAME), .high_sw(HIGH_FIRE_SW),
    .low_sw(LOW_FIRE_SW), .lock_ilk(LOCKOUT_ILK), .pre_ilk(PRE_IGN_ILK));
  // =====================================================================
  // clock, watchdog and shared tasks
  // =====================================================================
  // 100 ns clock
  initial
  begin
    forever #50 CLK = ~CLK;
  end
  // cut a hang short
  always @(posedge CLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      err_count++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, hi, got);
    checks++;
    if (got < lo || got > hi)
    begin
      err_count++;
      $display("mismatch %s exp %0d..%0d got %0d", nm, lo, hi, got);
    end
  endtask
  // count edges until an output reaches a level
  task automatic wait_out(input int i, input logic v, output int k);
    k = 0;
    while (outs[i] !== v && k < 3000)
    begin
      @(posedge CLK);
      k++;
    end
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1;
    WVALID <= 1;
    BREADY <= 1;
    do
    begin
      @(posedge CLK);
      if (AWREADY && AWVALID) AWVALID <= 0;
      if (WREADY && WVALID) WVALID <= 0;
    end while (BVALID !== 1'b1);
    BREADY <= 0;
    rs = BRESP;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1;
    RREADY <= 1;
    do
    begin
      @(posedge CLK);
      if (ARREADY && ARVALID) ARVALID <= 0;
    end while (RVALID !== 1'b1);
    RREADY <= 0;
    rd = RDATA;
    rs = RRESP;
  endtask
  // =====================================================================
  // main sequence
  // =====================================================================
  initial
  begin
    repeat (10) @(posedge CLK);
    RST <= 0;
    foreach (rows[i])
    begin
      axr(rows[i].a);
      chk("reg data", rows[i].d, rd);
      chk("reg resp", {30'h0, rows[i].r}, {30'h0, rs});
    end
    axw(POST_OFS, 32'h14);
    axr(POST_OFS);
    chk("post readback", 32'h14, rd);
    axw(8'h24, 32'h1);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, rs});
    // direct spark start, run, test in run, postpurge of 20 s
    DEMAND <= 1;
    VP_DEMAND <= 1;
    wait_out(IG, 1, n);
    chk("spark valves", 3'b110, {outs[3:2], outs[1]});
    wait_out(IG, 0, n);
    chk_rng("spark time", 30, 42, n);
    chk("run entered", 2'b10, {outs[UP], outs[LK]});
    wait_out(MD, 1, n);
    chk_rng("stabilize", 88, 106, n);
    TEST_SW <= 1;
    repeat (6) @(posedge CLK);
    chk("test low fire", 2'b01, {outs[MD], outs[6]});
    TEST_SW <= 0;
    wait_out(MD, 1, n);
    chk_rng("release again", 0, 8, n);
    DEMAND <= 0;
    VP_DEMAND <= 0;
    wait_out(UP, 0, n);
    chk_rng("demand drop", 0, 5, n);
    chk("post outputs", 4'b0011, {outs[3], outs[1], outs[BW], outs[6]});
    wait_out(BW, 0, n);
    chk_rng("postpurge", 185, 212, n);
    chk("no post fault", 1'b0, LOCKOUT);
    // direct spark without flame locks out, then restart
    flame_en <= 0;
    DEMAND <= 1;
    VP_DEMAND <= 1;
    wait_out(IG, 1, n);
    wait_out(LK, 1, n);
    chk_rng("no flame lockout", 30, 44, n);
    DEMAND <= 0;
    VP_DEMAND <= 0;
    flame_en <= 1;
    // restart from lockout and schedule the valve check after run
    axw(CTRL_OFS, 32'h3);
    repeat (5) @(posedge CLK);
    chk("restart", 1'b0, LOCKOUT);
    wait_out(BW, 0, n);
    // pilot start with test hold in prepurge, short pilot period
    SPARK_OPTION_LINK_A <= 0;
    TEST_SW <= 1;
    DEMAND <= 1;
    VP_DEMAND <= 1;
    repeat (300) @(posedge CLK);
    chk("test hold", 2'b10, {outs[5], outs[IG]});
    TEST_SW <= 0;
    wait_out(IG, 1, n);
    chk("pilot lit", 2'b10, {outs[1], outs[UP]});
    wait_out(UP, 1, n);
    chk_rng("pilot period", 30, 42, n);
    chk("both mains", 1'b1, DOWNSTREAM_FUEL_VALVE);
    wait_out(MD, 1, n);
    chk_rng("main and stab", 185, 212, n);
    DEMAND <= 0;
    VP_DEMAND <= 0;
    repeat (20) @(posedge CLK);
    chk("valve check", 1'b1, UPSTREAM_FUEL_VALVE);
    wait_out(BW, 0, n);
    chk("check done", 2'b00, {outs[UP], outs[LK]});
    give_verdict();
  end
endmodule
